/* hdl/nvsc_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module nvsc_ctrl
  import nvsc_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = NVSC_STORE_CYC,
  parameter int unsigned POWERUP_CYCLES = NVSC_POWERUP_CYC
) (
  // Clocking
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Request side
  input wire logic req_valid,
  input wire nvsc_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [NVSC_DATA_W-1:0] rsp_rdata,
  // Supply monitor, asynchronous
  input wire logic supply_ok,
  // Memory pins
  output nvsc_pins_t pins,
  output logic [NVSC_ADDR_W-1:0] mem_addr,
  input wire logic [NVSC_DATA_W-1:0] dq_in,
  output logic [NVSC_DATA_W-1:0] dq_out,
  output logic dq_oe
);

  typedef enum logic [3:0] {
    ST_PWRUP, ST_IDLE, ST_ST_OE, ST_ST_NV, ST_ST_INIT, ST_ST_REL, ST_ST_WAIT,
    ST_RC_SET, ST_RC_INIT, ST_RC_REL, ST_RC_WAIT, ST_RD_ACC, ST_WR_SET,
    ST_WR_PULSE, ST_WR_HOLD, ST_REC
  } nvsc_state_t;

  nvsc_state_t state_r, state_nxt;
  nvsc_pins_t pins_nxt;
  logic tmr_load, tmr_zero;
  logic [NVSC_CNT_W-1:0] tmr_val;
  logic [NVSC_DATA_W-1:0] dq_s1_r, dq_s2_r;
  logic sup_s1_r, sup_s2_r;
  logic accept;
  logic pwr_arm_r;

  nvsc_timer #(.CNT_W(NVSC_CNT_W)) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .load(tmr_load),
    .value(tmr_val),
    .zero(tmr_zero)
  );

  // Two-stage synchronisers for pin-level inputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
      sup_s1_r <= 1'b0;
      sup_s2_r <= 1'b0;
    end else if (clk_en) begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
      sup_s1_r <= supply_ok;
      sup_s2_r <= sup_s1_r;
    end
  end

  assign accept = req_valid && req_ready && (state_r == ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (state_r)
      ST_PWRUP: begin
        // Timer still reads zero here, so leaving must wait for the load
        if (pwr_arm_r) begin
          tmr_load = 1'b1;
          tmr_val = NVSC_CNT_W'(POWERUP_CYCLES - 1);
        end else if (tmr_zero) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          case (req.cmd)
            NVSC_CMD_STORE: state_nxt = sup_s2_r ? ST_ST_OE : ST_IDLE;
            NVSC_CMD_RECALL: state_nxt = ST_RC_SET;
            NVSC_CMD_WRITE: state_nxt = ST_WR_SET;
            default: begin
              state_nxt = ST_RD_ACC;
              tmr_load = 1'b1;
              tmr_val = NVSC_CNT_W'(NVSC_ACCESS_CYC - 1);
            end
          endcase
        end
      end
      ST_ST_OE: state_nxt = ST_ST_NV;
      ST_ST_NV: begin
        state_nxt = ST_ST_INIT;
        tmr_load = 1'b1;
        tmr_val = NVSC_CNT_W'(NVSC_INIT_CYC - 1);
      end
      ST_ST_INIT: begin
        if (tmr_zero) begin
          state_nxt = ST_ST_REL;
        end
      end
      ST_ST_REL: begin
        state_nxt = ST_ST_WAIT;
        tmr_load = 1'b1;
        tmr_val = NVSC_CNT_W'(STORE_CYCLES - NVSC_INIT_CYC - 2);
      end
      ST_ST_WAIT: begin
        if (tmr_zero) begin
          state_nxt = ST_REC;
        end
      end
      ST_RC_SET: begin
        state_nxt = ST_RC_INIT;
        tmr_load = 1'b1;
        tmr_val = NVSC_CNT_W'(NVSC_INIT_CYC - 1);
      end
      ST_RC_INIT: begin
        if (tmr_zero) begin
          state_nxt = ST_RC_REL;
        end
      end
      ST_RC_REL: begin
        state_nxt = ST_RC_WAIT;
        tmr_load = 1'b1;
        tmr_val = NVSC_CNT_W'(NVSC_RECALL_CYC - NVSC_INIT_CYC - 2);
      end
      ST_RC_WAIT: begin
        if (tmr_zero) begin
          state_nxt = ST_REC;
        end
      end
      ST_RD_ACC: begin
        if (tmr_zero) begin
          state_nxt = ST_REC;
        end
      end
      ST_WR_SET: begin
        state_nxt = ST_WR_PULSE;
        tmr_load = 1'b1;
        tmr_val = NVSC_CNT_W'(NVSC_WPULSE_CYC - 1);
      end
      ST_WR_PULSE: begin
        if (tmr_zero) begin
          state_nxt = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: state_nxt = ST_REC;
      ST_REC: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Pin levels follow the state being entered, so pins change on the same edge
  always_comb begin
    pins_nxt = NVSC_PINS_IDLE;
    case (state_nxt)
      ST_ST_OE: pins_nxt = '{chip_en_n: 1'b0, write_en_n: 1'b1, out_en_n: 1'b1,
                             nv_request_low: 1'b1};
      ST_ST_NV: pins_nxt = '{chip_en_n: 1'b0, write_en_n: 1'b1, out_en_n: 1'b1,
                             nv_request_low: 1'b0};
      ST_ST_INIT: pins_nxt = '{chip_en_n: 1'b0, write_en_n: 1'b0, out_en_n: 1'b1,
                               nv_request_low: 1'b0};
      ST_ST_REL: pins_nxt = '{chip_en_n: 1'b0, write_en_n: 1'b1, out_en_n: 1'b1,
                              nv_request_low: 1'b0};
      ST_RC_SET: pins_nxt = '{chip_en_n: 1'b0, write_en_n: 1'b1, out_en_n: 1'b0,
                              nv_request_low: 1'b1};
      ST_RC_INIT: pins_nxt = '{chip_en_n: 1'b0, write_en_n: 1'b1, out_en_n: 1'b0,
                               nv_request_low: 1'b0};
      // Only nv request is released to end the recall initiation
      ST_RC_REL: pins_nxt = '{chip_en_n: 1'b0, write_en_n: 1'b1, out_en_n: 1'b0,
                              nv_request_low: 1'b1};
      ST_RD_ACC: pins_nxt = '{chip_en_n: 1'b0, write_en_n: 1'b1, out_en_n: 1'b0,
                              nv_request_low: 1'b1};
      // Output enable stays high through writes to avoid bus contention
      ST_WR_SET, ST_WR_HOLD: pins_nxt = '{chip_en_n: 1'b0, write_en_n: 1'b1,
                                          out_en_n: 1'b1, nv_request_low: 1'b1};
      ST_WR_PULSE: pins_nxt = '{chip_en_n: 1'b0, write_en_n: 1'b0, out_en_n: 1'b1,
                                nv_request_low: 1'b1};
      default: pins_nxt = NVSC_PINS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_PWRUP;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Power-up wait is loaded on the first enabled cycle after reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwr_arm_r <= 1'b1;
    end else if (clk_en) begin
      pwr_arm_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pins <= NVSC_PINS_IDLE;
      mem_addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
    end else if (clk_en) begin
      pins <= pins_nxt;
      if (accept) begin
        mem_addr <= req.addr;
        dq_out <= req.wdata;
      end
      // Data is driven only while writing
      dq_oe <= (state_nxt == ST_WR_SET) || (state_nxt == ST_WR_PULSE) ||
               (state_nxt == ST_WR_HOLD);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_rdata <= '0;
    end else if (clk_en) begin
      req_ready <= (state_nxt == ST_IDLE) && !(pwr_arm_r);
      rsp_valid <= (state_r == ST_REC) ||
                   (accept && (req.cmd == NVSC_CMD_STORE) && !sup_s2_r);
      rsp_err <= accept && (req.cmd == NVSC_CMD_STORE) && !sup_s2_r;
      if ((state_r == ST_RD_ACC) && tmr_zero) begin
        rsp_rdata <= dq_s2_r;
      end
    end
  end

  AST_STORE_PINS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_ST_INIT) |-> (pins == 4'h2))
    else $error("store pin state wrong");
  AST_RECALL_PINS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_RC_INIT) |-> (pins == 4'h4))
    else $error("recall pin state wrong");
  AST_NO_DQ_NV: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pins.nv_request_low |-> !dq_oe)
    else $error("data driven during nonvolatile cycle");
  AST_OE_BEFORE_NV: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(pins.nv_request_low) && pins.out_en_n |-> $past(pins.out_en_n)
      && !$past(pins.chip_en_n))
    else $error("output enable not high before nv request");
  AST_WE_AFTER_NV: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(pins.write_en_n) && !pins.nv_request_low |->
      !$past(pins.nv_request_low) && !$past(pins.chip_en_n))
    else $error("write fell before nv request setup");
  AST_RECALL_REL: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_RC_INIT) && (state_nxt == ST_RC_REL) && clk_en |=>
      pins.nv_request_low && pins.write_en_n && !pins.chip_en_n)
    else $error("recall not ended by nv request");
  AST_INIT_WIDTH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(pins.write_en_n) && !pins.nv_request_low |-> (pins == 4'h2)
      ##1 (pins == 4'h2 || pins == 4'h6))
    else $error("store initiation too short");
  AST_IDLE_BETWEEN: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_REC) |-> (pins == NVSC_PINS_IDLE) && !dq_oe && !req_ready)
    else $error("pins not released between operations");
  AST_PWRUP_QUIET: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_PWRUP) |-> (pins == NVSC_PINS_IDLE) && !req_ready)
    else $error("access during power-up copy");
  AST_LOWV_STORE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    accept && (req.cmd == NVSC_CMD_STORE) && !sup_s2_r && clk_en |=>
      (state_r == ST_IDLE) && rsp_err)
    else $error("store started on low supply");

  COV_STORE: cover property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_ST_WAIT) ##1 (state_r == ST_REC));
  COV_RECALL: cover property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_RC_WAIT) ##1 (state_r == ST_REC));
  COV_READ: cover property (@(posedge sys_clk) disable iff (sys_rst)
    (state_r == ST_RD_ACC) ##1 (state_r == ST_REC));
  COV_LOWV: cover property (@(posedge sys_clk) disable iff (sys_rst)
    accept && (req.cmd == NVSC_CMD_STORE) && !sup_s2_r);

endmodule : nvsc_ctrl
`default_nettype wire

/* hdl/nvsc_pkg.sv */
package nvsc_pkg;

  localparam int unsigned NVSC_ADDR_W = 11;
  localparam int unsigned NVSC_DATA_W = 8;
  localparam int unsigned NVSC_CNT_W = 18;

  localparam int unsigned NVSC_CLK_PERIOD_NS = 40;
  localparam int unsigned NVSC_SETUP_NS = 5;
  localparam int unsigned NVSC_INIT_NS = 25;
  localparam int unsigned NVSC_STORE_MS = 10;
  localparam int unsigned NVSC_RECALL_US = 20;
  localparam int unsigned NVSC_POWERUP_US = 650;
  localparam int unsigned NVSC_ACCESS_NS = 45;
  localparam int unsigned NVSC_WPULSE_NS = 35;
  localparam int unsigned NVSC_SYNC_STAGES = 2;

  // Minimum times, rounded up to whole cycles; the access count also adds the synchroniser stages
  localparam int unsigned NVSC_INIT_CYC =
    (NVSC_INIT_NS + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS;
  localparam int unsigned NVSC_SETUP_CYC =
    (NVSC_SETUP_NS + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS;
  localparam int unsigned NVSC_STORE_CYC =
    (NVSC_STORE_MS * 1000000 + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS;
  localparam int unsigned NVSC_RECALL_CYC =
    (NVSC_RECALL_US * 1000 + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS;
  localparam int unsigned NVSC_POWERUP_CYC =
    (NVSC_POWERUP_US * 1000 + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS;
  localparam int unsigned NVSC_ACCESS_CYC =
    (NVSC_ACCESS_NS + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS + NVSC_SYNC_STAGES;
  localparam int unsigned NVSC_WPULSE_CYC =
    (NVSC_WPULSE_NS + NVSC_CLK_PERIOD_NS - 1) / NVSC_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    NVSC_CMD_READ,
    NVSC_CMD_WRITE,
    NVSC_CMD_STORE,
    NVSC_CMD_RECALL
  } nvsc_cmd_t;

  // Control pins of the memory, all active low
  typedef struct packed {
    logic chip_en_n;
    logic write_en_n;
    logic out_en_n;
    logic nv_request_low;
  } nvsc_pins_t;

  localparam nvsc_pins_t NVSC_PINS_IDLE = 4'hf;

  typedef struct packed {
    nvsc_cmd_t cmd;
    logic [NVSC_ADDR_W-1:0] addr;
    logic [NVSC_DATA_W-1:0] wdata;
  } nvsc_req_t;

endpackage : nvsc_pkg

/* hdl/nvsc_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module nvsc_timer #(
  parameter int unsigned CNT_W = 18
) (
  // Clocking
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] value,
  // Status
  output logic zero
);

  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (load) begin
        cnt_r <= value;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
    end
  end

  assign zero = (cnt_r == '0);

endmodule : nvsc_timer
`default_nettype wire

/* sim/nvsc_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module nvsc_mem_model
  import nvsc_pkg::*;
#(
  parameter int unsigned STORE_CYC = 40,
  parameter int unsigned RECALL_CYC = NVSC_RECALL_CYC,
  parameter int unsigned PU_CYC = 20
) (
  // Clocking
  input wire logic sys_clk,
  // Supply and control pins
  input wire logic supply_ok,
  input wire nvsc_pins_t pins,
  input wire logic [NVSC_ADDR_W-1:0] mem_addr,
  input wire logic [NVSC_DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  // Memory answers
  output logic [NVSC_DATA_W-1:0] dq_in,
  output logic viol
);
  localparam nvsc_pins_t PS_STORE = 4'h2;
  localparam nvsc_pins_t PS_RECALL = 4'h4;
  localparam nvsc_pins_t PS_READ = 4'h5;
  logic [NVSC_DATA_W-1:0] sram [2**NVSC_ADDR_W];
  logic [NVSC_DATA_W-1:0] ee [2**NVSC_ADDR_W];
  logic [NVSC_DATA_W-1:0] dq_r = 8'h00;
  logic viol_r = 1'b0;
  nvsc_pins_t prev_r = NVSC_PINS_IDLE;
  logic sup_r = 1'b0;
  logic is_store_r = 1'b0;
  int unsigned busy_r = 0;
  logic drive;

  initial begin
    for (int a = 0; a < 2**NVSC_ADDR_W; a++) begin
      ee[a] = 8'(a) ^ 8'h5a;
    end
  end

  assign drive = (pins == PS_READ) && (busy_r == 0) && sup_r;
  assign dq_in = dq_r;
  assign viol = viol_r;

  always @(posedge sys_clk) begin
    prev_r <= pins;
    sup_r <= supply_ok;
    // Contention on the shared data lines
    viol_r <= dq_oe && drive;
    if (supply_ok && !sup_r) begin
      busy_r <= PU_CYC;
      is_store_r <= 1'b0;
    end else if (busy_r != 0) begin
      if (is_store_r && !supply_ok) begin
        busy_r <= 0;
      end else if (busy_r == 1) begin
        for (int a = 0; a < 2**NVSC_ADDR_W; a++) begin
          if (is_store_r) ee[a] <= sram[a];
          else sram[a] <= ee[a];
        end
        busy_r <= 0;
      end else begin
        busy_r <= busy_r - 1;
      end
    end else if (pins == PS_STORE && prev_r != PS_STORE && supply_ok) begin
      busy_r <= STORE_CYC;
      is_store_r <= 1'b1;
      // Only the initiating pin may move on entry
      if ($countones(pins ^ prev_r) != 1) viol_r <= 1'b1;
    end else if (pins == PS_RECALL && prev_r != PS_RECALL) begin
      busy_r <= RECALL_CYC;
      is_store_r <= 1'b0;
    end else if (!pins.chip_en_n && !pins.write_en_n && pins.nv_request_low && dq_oe) begin
      sram[mem_addr] <= dq_out;
    end
    // Released lines show a changing pattern, toggling between the old byte and its inverse each cycle
    dq_r <= drive ? sram[mem_addr] : ~dq_r;
  end
endmodule : nvsc_mem_model
`default_nettype wire

/* sim/nvsram_store_recall_control_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module nvsram_store_recall_control_tb_top;
  import nvsc_pkg::*;
  localparam int unsigned ST_CYC = 40;
  localparam int unsigned PU_CYC = 20;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  nvsc_req_t req = '0;
  logic supply_ok = 1'b0;
  logic req_ready, rsp_valid, rsp_err, dq_oe, viol;
  logic [NVSC_DATA_W-1:0] rsp_rdata, dq_in, dq_out, got_d;
  logic [NVSC_ADDR_W-1:0] mem_addr;
  logic [NVSC_ADDR_W-1:0] ad [4];
  logic [NVSC_DATA_W-1:0] sh_sram [2**NVSC_ADDR_W];
  logic [NVSC_DATA_W-1:0] sh_ee [2**NVSC_ADDR_W];
  nvsc_pins_t pins;
  int bad_count = 0;
  int compares = 0;

  nvsc_ctrl #(.STORE_CYCLES(ST_CYC), .POWERUP_CYCLES(PU_CYC)) dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
    .supply_ok(supply_ok), .pins(pins), .mem_addr(mem_addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  nvsc_mem_model #(.STORE_CYC(ST_CYC), .PU_CYC(PU_CYC)) mem (.sys_clk(sys_clk),
    .supply_ok(supply_ok), .pins(pins), .mem_addr(mem_addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .dq_in(dq_in), .viol(viol));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic bad(input string msg);
    bad_count++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) bad($sformatf("data %h expected %h", got, exp));
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) bad($sformatf("flag %b expected %b", got, exp));
  endtask : chk1

  function automatic logic [7:0] ee_init(input int a);
    return 8'(a) ^ 8'h5a;
  endfunction : ee_init

  // Called just after an edge; returns just after an edge
  task automatic op(input nvsc_cmd_t c, input logic [10:0] a, input logic [7:0] d,
                    input logic e);
    int n;
    req_valid = 1'b1;
    req = '{cmd: c, addr: a, wdata: d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(req_ready === 1'b1 && clk_en) && n < 2000);
    #1;
    req_valid = 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 4000);
    got_d = rsp_rdata;
    if (n >= 4000) begin
      bad("no answer");
      end_sim();
    end
    chk1(rsp_err, e);
    #1;
  endtask : op

  task automatic rd(input logic [10:0] a);
    op(NVSC_CMD_READ, a, 8'h00, 1'b0);
    chk8(got_d, sh_sram[a]);
  endtask : rd

  // Clock enable gaps stretch every wait of the controller
  always @(posedge sys_clk) begin
    #1;
    clk_en = ($urandom_range(7) != 0);
  end

  always @(posedge sys_clk) begin
    if (viol === 1'b1) bad("pin order or bus contention");
  end

  initial begin
    int t;
    logic [7:0] d;
    void'($urandom(89651));
    for (int a = 0; a < 2**NVSC_ADDR_W; a++) sh_ee[a] = ee_init(a);
    sh_sram = sh_ee;
    ad = '{11'h000, 11'h7ff, 11'($urandom_range(2047)), 11'($urandom_range(2047))};
    repeat (12) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    supply_ok = 1'b1;
    t = 0;
    while (req_ready !== 1'b1 && t < 2000) begin
      @(posedge sys_clk);
      #1;
      t++;
    end
    chk1((t >= PU_CYC) && (t < 2000), 1'b1);
    for (int i = 0; i < 4; i++) rd(ad[i]);
    $display("test powerup done");
    for (int i = 0; i < 16; i++) begin
      t = $urandom_range(3);
      d = 8'($urandom);
      if ($urandom_range(1)) begin
        op(NVSC_CMD_WRITE, ad[t], d, 1'b0);
        sh_sram[ad[t]] = d;
      end else begin
        rd(ad[t]);
      end
    end
    $display("test read write done");
    op(NVSC_CMD_STORE, 11'h000, 8'h00, 1'b0);
    sh_ee = sh_sram;
    op(NVSC_CMD_STORE, 11'h000, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      op(NVSC_CMD_WRITE, ad[i], ~sh_ee[ad[i]], 1'b0);
      sh_sram[ad[i]] = ~sh_ee[ad[i]];
      rd(ad[i]);
    end
    op(NVSC_CMD_RECALL, 11'h000, 8'h00, 1'b0);
    sh_sram = sh_ee;
    for (int i = 0; i < 4; i++) rd(ad[i]);
    $display("test store recall done");
    op(NVSC_CMD_WRITE, ad[0], 8'h3c ^ sh_ee[ad[0]], 1'b0);
    supply_ok = 1'b0;
    // Enough edges for the synchroniser even with clock enable gaps
    repeat (40) @(posedge sys_clk);
    #1;
    op(NVSC_CMD_STORE, 11'h000, 8'h00, 1'b1);
    supply_ok = 1'b1;
    sh_sram = sh_ee;
    repeat (PU_CYC + 10) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 4; i++) rd(ad[i]);
    $display("test supply drop done");
    end_sim();
  end
endmodule : nvsram_store_recall_control_tb_top
`default_nettype wire
